// file: rtl/ptpc_top.sv
`include "ptpc_consts.svh"
module ptpc_top (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // software register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  // core user side
  input wire logic addr_vld_in,
  input wire logic [31:0] addr_in,
  input wire logic [1:0] base_hit_in,
  input wire logic s_data_in,
  input wire logic s_data_vld_in,
  input wire logic s_src_en_in,
  input wire logic bar_rd_in,
  input wire logic bar_wr_in,
  // peripheral side
  input wire logic periph_busy_in,
  input wire logic peripheral_select_in,
  input wire logic fatal_in,
  // controls to core
  output logic s_term_out,
  output logic s_ready_out,
  output logic s_abort_out,
  output logic [9:0] local_ptr_out
);
  ptpc_pkg::ptpc_state_t st_r, st_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [3:0] lat_r, lat_nxt;
  logic [9:0] limit_r, limit_nxt;
  logic [3:0] stat_r, stat_nxt;
  logic [3:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] timer_r, timer_nxt;
  logic retry_r, retry_nxt;
  logic inuse_r, inuse_nxt;
  logic abort_r, abort_nxt;
  logic term_r, term_nxt;
  logic ready_r, ready_nxt;
  logic [4:0] age_r, age_nxt;
  logic latency_done;
  logic hit;
  logic sel_periph;
  logic p_term, p_ready;
  logic c_term, c_ready;
  logic [3:0] events;
  ptpc_ptr_if pif ();

  ptpc_ptr u_ptr (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .p(pif)
  );

  assign hit = |base_hit_in;
  assign latency_done = (timer_r <= `PTPC_LAT_READY);
  assign pif.load = addr_vld_in;
  assign pif.start = addr_in[11:2];
  assign pif.limit = limit_r;
  // advance on data taken for writes, on source enable for reads
  assign pif.inc = (bar_wr_in & s_data_vld_in) | (bar_rd_in & s_src_en_in);

  // in-use flag stretches the one-cycle bar zero hit over the transaction
  always_comb begin
    inuse_nxt = inuse_r;
    if (base_hit_in[0]) begin
      inuse_nxt = 1'b1;
    end else if (!s_data_in) begin
      inuse_nxt = 1'b0;
    end
  end

  // region select: split decode or bar zero with its in-use flag
  always_comb begin
    if (ctrl_r[`PTPC_BIT_MULTI]) begin
      sel_periph = base_hit_in[0] | inuse_r;
    end else if (ctrl_r[`PTPC_BIT_SPLIT]) begin
      sel_periph = peripheral_select_in;
    end else begin
      sel_periph = 1'b1;
    end
  end

  // peripheral controls: retry when busy else burst or latency disconnect
  always_comb begin
    if (ctrl_r[`PTPC_BIT_NONDET]) begin
      p_term = periph_busy_in;
      p_ready = ~periph_busy_in;
    end else if (retry_r) begin
      p_term = 1'b1;
      p_ready = 1'b0;
    end else if (ctrl_r[`PTPC_BIT_BURST]) begin
      p_term = 1'b0;
      p_ready = latency_done;
    end else begin
      p_term = latency_done;
      p_ready = latency_done;
    end
  end

  // registers disconnect with data, except the wait state that WAITST forces on an address phase hit
  always_comb begin
    c_term = sel_periph ? p_term : 1'b1;
    c_ready = sel_periph ? p_ready : 1'b1;
  end

  // combinational path only in non-deterministic mode without the wait state
  always_comb begin
    if (ctrl_r[`PTPC_BIT_NONDET] && !ctrl_r[`PTPC_BIT_WAITST]) begin
      s_term_out = c_term;
      s_ready_out = c_ready;
    end else begin
      s_term_out = term_r;
      s_ready_out = ready_r;
    end
  end

  // transaction tracking, timer, retry capture, abort
  always_comb begin
    st_nxt = st_r;
    timer_nxt = timer_r;
    retry_nxt = retry_r;
    abort_nxt = abort_r;
    age_nxt = age_r;
    term_nxt = c_term;
    ready_nxt = c_ready;
    if (timer_r != 4'h0) begin
      timer_nxt = timer_r - 4'h1;
    end
    if (age_r != 5'h1F) begin
      age_nxt = age_r + 5'h01;
    end
    case (st_r)
      ptpc_pkg::PTPC_IDLE: begin
        abort_nxt = 1'b0;
        if (addr_vld_in) begin
          st_nxt = ptpc_pkg::PTPC_ADDR;
          timer_nxt = lat_r;
          retry_nxt = periph_busy_in;
          age_nxt = 5'h00;
        end
      end
      ptpc_pkg::PTPC_ADDR: begin
        if (s_data_in || hit) begin
          st_nxt = ptpc_pkg::PTPC_DATA;
        end else if (age_r > 5'h02) begin
          st_nxt = ptpc_pkg::PTPC_IDLE;
        end
        if (ctrl_r[`PTPC_BIT_WAITST] && hit) begin
          term_nxt = 1'b0;
          ready_nxt = 1'b0;
        end
      end
      ptpc_pkg::PTPC_DATA: begin
        if (ctrl_r[`PTPC_BIT_ABTEN] && (pif.over || fatal_in)) begin
          abort_nxt = 1'b1;
        end
        if (!s_data_in) begin
          st_nxt = ptpc_pkg::PTPC_IDLE;
        end
      end
      default: begin
        st_nxt = ptpc_pkg::PTPC_IDLE;
      end
    endcase
  end

  // software registers and sticky events; event set wins over read clear
  assign events[`PTPC_EV_ABORT] = abort_nxt & ~abort_r;
  assign events[`PTPC_EV_RETRY] = (st_r == ptpc_pkg::PTPC_ADDR) && hit && retry_r;
  assign events[`PTPC_EV_LATE] = (st_r != ptpc_pkg::PTPC_IDLE) && (age_r == `PTPC_FIRST_PHASE_CLKS)
    && !latency_done;
  assign events[`PTPC_EV_DONE] = (st_r == ptpc_pkg::PTPC_DATA) && !s_data_in;
  always_comb begin
    ctrl_nxt = ctrl_r;
    lat_nxt = lat_r;
    mask_nxt = mask_r;
    limit_nxt = limit_r;
    stat_nxt = stat_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `PTPC_ADDR_CTRL: ctrl_nxt = reg_wdata_in[7:0];
        `PTPC_ADDR_LAT: lat_nxt = reg_wdata_in[3:0];
        `PTPC_ADDR_MASK: mask_nxt = reg_wdata_in[3:0];
        `PTPC_ADDR_LIMIT: limit_nxt = reg_wdata_in[9:0];
        default: begin
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `PTPC_ADDR_CTRL: rdata_nxt = {24'h000000, ctrl_r};
        `PTPC_ADDR_LAT: rdata_nxt = {28'h0000000, lat_r};
        `PTPC_ADDR_STAT: begin
          rdata_nxt = {20'h00000, 2'b00, st_r, retry_r, abort_r, inuse_r, latency_done, stat_r};
          stat_nxt = 4'h0;
        end
        `PTPC_ADDR_MASK: rdata_nxt = {28'h0000000, mask_r};
        `PTPC_ADDR_PTR: rdata_nxt = {22'h000000, pif.ptr};
        `PTPC_ADDR_LIMIT: rdata_nxt = {22'h000000, limit_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    stat_nxt = stat_nxt | events;
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= ptpc_pkg::PTPC_IDLE;
      ctrl_r <= `PTPC_CTRL_RESET;
      lat_r <= `PTPC_LAT_RESET;
      limit_r <= `PTPC_LIMIT_RESET;
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      timer_r <= 4'h0;
      retry_r <= 1'b0;
      inuse_r <= 1'b0;
      abort_r <= 1'b1;
      term_r <= 1'b0;
      ready_r <= 1'b1;
      age_r <= 5'h1F;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      lat_r <= lat_nxt;
      limit_r <= limit_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      timer_r <= timer_nxt;
      retry_r <= retry_nxt;
      inuse_r <= inuse_nxt;
      abort_r <= abort_nxt;
      term_r <= term_nxt;
      ready_r <= ready_nxt;
      age_r <= age_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign irq_out = |(stat_r & mask_r);
  assign s_abort_out = abort_r;
  assign local_ptr_out = pif.ptr;

  sequence txn_start_s;
    (st_r == ptpc_pkg::PTPC_IDLE) && addr_vld_in;
  endsequence
  sequence in_txn_s;
    st_r != ptpc_pkg::PTPC_IDLE;
  endsequence
  retry_capture_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    txn_start_s |=> retry_r == $past(periph_busy_in)) else $error("retry not captured");
  retry_stable_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (in_txn_s ##1 in_txn_s) |-> $stable(retry_r)) else $error("retry changed mid txn");
  timer_load_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    txn_start_s |=> timer_r == $past(lat_r)) else $error("latency timer not loaded");
  abort_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (abort_r && st_r == ptpc_pkg::PTPC_DATA && s_data_in) |=> abort_r)
    else $error("abort dropped early");
  abort_idle_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (st_r == ptpc_pkg::PTPC_IDLE) |=> !abort_r) else $error("abort while idle");
  retry_ctrl_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (retry_r && sel_periph && !ctrl_r[`PTPC_BIT_NONDET]) |=> (term_r && !ready_r))
    else $error("retry controls wrong");
  reg_ctrl_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!sel_periph && !(st_r == ptpc_pkg::PTPC_ADDR && hit)) |=> (term_r && ready_r))
    else $error("register region not disconnect");
  inuse_clr_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!base_hit_in[0] && !s_data_in) |=> !inuse_r) else $error("in use not cleared");
  ready_done_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!retry_r && sel_periph && ctrl_r[2:0] == 3'b000) |=> (term_r == ready_r))
    else $error("latency controls split");
endmodule

// file: rtl/ptpc_consts.svh
`ifndef PTPC_CONSTS_SVH
`define PTPC_CONSTS_SVH
`define PTPC_ADDR_CTRL 4'h0
`define PTPC_ADDR_LAT 4'h1
`define PTPC_ADDR_STAT 4'h2
`define PTPC_ADDR_MASK 4'h3
`define PTPC_ADDR_PTR 4'h4
`define PTPC_ADDR_LIMIT 4'h5
`define PTPC_CTRL_RESET 8'h00
`define PTPC_LAT_RESET 4'h3
`define PTPC_LAT_READY 4'h3
`define PTPC_LIMIT_RESET 10'h3FF
`define PTPC_FIRST_PHASE_CLKS 5'h10
`define PTPC_BIT_NONDET 0
`define PTPC_BIT_WAITST 1
`define PTPC_BIT_BURST 2
`define PTPC_BIT_SPLIT 3
`define PTPC_BIT_MULTI 4
`define PTPC_BIT_ABTEN 5
`define PTPC_EV_ABORT 0
`define PTPC_EV_RETRY 1
`define PTPC_EV_LATE 2
`define PTPC_EV_DONE 3
`endif

// file: rtl/ptpc_pkg.sv
package ptpc_pkg;
  typedef enum logic [1:0] {
    PTPC_WAIT = 2'b00,
    PTPC_NORMAL = 2'b01,
    PTPC_RETRY = 2'b10,
    PTPC_DISC = 2'b11
  } ptpc_mode_t;
  typedef enum logic [1:0] {
    PTPC_IDLE = 2'b00,
    PTPC_ADDR = 2'b01,
    PTPC_DATA = 2'b10
  } ptpc_state_t;
endpackage

// file: rtl/ptpc_ptr_if.sv
interface ptpc_ptr_if;
  logic load;
  logic inc;
  logic [9:0] start;
  logic [9:0] limit;
  logic [9:0] ptr;
  logic over;
  modport owner (output load, output inc, output start, output limit, input ptr, input over);
  modport counter (input load, input inc, input start, input limit, output ptr, output over);
endinterface

// file: rtl/ptpc_ptr.sv
`include "ptpc_consts.svh"
module ptpc_ptr (
  input wire logic mclk_in,
  input wire logic reset_in,
  ptpc_ptr_if.counter p
);
  logic [9:0] ptr_r;
  logic [9:0] ptr_nxt;
  logic over_r;
  logic over_nxt;
  always_comb begin
    ptr_nxt = ptr_r;
    over_nxt = over_r;
    if (p.load) begin
      ptr_nxt = p.start;
      over_nxt = 1'b0;
    end else if (p.inc) begin
      // a step at the limit holds the pointer and sets over: the initiator burst beyond the block
      if (ptr_r >= p.limit) begin
        over_nxt = 1'b1;
      end else begin
        ptr_nxt = ptr_r + 10'h001;
      end
    end
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ptr_r <= 10'h000;
      over_r <= 1'b0;
    end else begin
      ptr_r <= ptr_nxt;
      over_r <= over_nxt;
    end
  end
  assign p.ptr = ptr_r;
  assign p.over = over_r;
  ptr_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!p.load && !p.inc) |=> $stable(ptr_r)) else $error("pointer moved without cause");
  ptr_step_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (!p.load && p.inc && ptr_r < p.limit) |=> ptr_r == $past(ptr_r) + 10'h001)
    else $error("pointer did not step");
endmodule

// file: verification/ptpc_core_model.sv
module ptpc_core_model (
  // clock
  input wire logic mclk_in,
  // controls from user logic
  input wire logic s_term_in,
  input wire logic s_ready_in,
  input wire logic s_abort_in,
  // transaction signals to user logic
  output logic addr_vld_out,
  output logic [31:0] addr_out,
  output logic [1:0] base_hit_out,
  output logic s_data_out,
  output logic s_data_vld_out,
  output logic s_src_en_out,
  output logic bar_rd_out,
  output logic bar_wr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signaled_abort_status_bit = 1'b0;
  logic [1:0] first_mode;
  logic ab_seen;
  logic ab_drop;
  logic stuck;
  int wait_cnt;
  initial begin
    addr_vld_out = 1'b0;
    addr_out = 32'h0;
    base_hit_out = 2'h0;
    s_data_out = 1'b0;
    s_data_vld_out = 1'b0;
    s_src_en_out = 1'b0;
    bar_rd_out = 1'b0;
    bar_wr_out = 1'b0;
  end
  task automatic txn(input logic [31:0] a, input logic w, input int beats, input logic [1:0] h);
    int n;
    int ac;
    logic fin;
    logic x;
    logic [1:0] m;
    n = 0;
    ac = 0;
    fin = 1'b0;
    first_mode = 2'h0;
    ab_seen = 1'b0;
    ab_drop = 1'b0;
    wait_cnt = 0;
    @(posedge mclk_in);
    addr_vld_out <= 1'b1;
    addr_out <= a;
    bar_wr_out <= w;
    bar_rd_out <= !w;
    @(posedge mclk_in);
    addr_vld_out <= 1'b0;
    base_hit_out <= h;
    @(posedge mclk_in);
    base_hit_out <= 2'h0;
    s_data_out <= 1'b1;
    // controls looked at every cycle until retry or disconnect, the last beat or three abort cycles, at most 20 cycles
    for (int k = 0; k < 20 && !fin; k++) begin
      @(negedge mclk_in);
      m = {s_term_in, s_ready_in};
      x = 1'b0;
      if (s_abort_in) begin
        signaled_abort_status_bit = 1'b1;
        ab_seen = 1'b1;
        ac++;
        fin = ac > 2;
      end else begin
        ab_drop |= ab_seen;
        if (first_mode == 2'h0) first_mode = m;
        if (m == 2'h0) wait_cnt++;
        x = m[0];
        if (x) n++;
        fin = m[1] || (x && n >= beats);
      end
      @(posedge mclk_in);
      s_data_vld_out <= w & x;
      s_src_en_out <= !w & x;
    end
    stuck = !fin;
    // the abort flop lags its cause by a cycle, so look once more before the bus lets go
    @(negedge mclk_in);
    if (s_abort_in) begin
      signaled_abort_status_bit = 1'b1;
      ab_seen = 1'b1;
    end
    @(posedge mclk_in);
    s_data_out <= 1'b0;
    s_data_vld_out <= 1'b0;
    s_src_en_out <= 1'b0;
    bar_rd_out <= 1'b0;
    bar_wr_out <= 1'b0;
    // released bus shows the inverse, not a stale address
    addr_out <= ~a;
  endtask
endmodule

// file: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic rw = 1'b0;
  logic rr = 1'b0;
  logic busy = 1'b0;
  logic sel = 1'b0;
  logic fatal = 1'b0;
  logic [31:0] rdata;
  logic [31:0] addr;
  logic [1:0] hit;
  logic [9:0] ptr;
  logic irq, av, sd, dv, se, brd, bwr, term, rdy, abort;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] tc [5] = '{8'h09, 8'h09, 8'h09, 8'h11, 8'h11};
  logic ts [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
  logic tz [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
  logic [1:0] th [5] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
  logic [1:0] te [5] = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
  always #4 mclk_in = ~mclk_in;
  ptpc_top dut (.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(rw), .reg_rd_in(rr), .reg_rdata_out(rdata), .irq_out(irq), .addr_vld_in(av),
    .addr_in(addr), .base_hit_in(hit), .s_data_in(sd), .s_data_vld_in(dv), .s_src_en_in(se),
    .bar_rd_in(brd), .bar_wr_in(bwr), .periph_busy_in(busy), .peripheral_select_in(sel),
    .fatal_in(fatal), .s_term_out(term), .s_ready_out(rdy), .s_abort_out(abort),
    .local_ptr_out(ptr));
  ptpc_core_model core (.mclk_in(mclk_in), .s_term_in(term), .s_ready_in(rdy),
    .s_abort_in(abort), .addr_vld_out(av), .addr_out(addr), .base_hit_out(hit),
    .s_data_out(sd), .s_data_vld_out(dv), .s_src_en_out(se), .bar_rd_out(brd),
    .bar_wr_out(bwr));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge mclk_in);
    rw <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk_in);
    ra <= a;
    rr <= 1'b1;
    @(posedge mclk_in);
    rr <= 1'b0;
    @(negedge mclk_in);
    chk($sformatf("reg %0h", a), e, rdata & m);
  endtask
  task automatic go(input logic [31:0] a, input logic w, input int b, input logic [1:0] h,
    input logic [1:0] e, input logic m);
    core.txn(a, w, b, h);
    @(negedge mclk_in);
    chk("ended", 32'h0, core.stuck);
    if (m) chk("mode", e, core.first_mode);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    chk("abort", 32'h1, abort);
    reset_in <= 1'b0;
    rd(4'h0, 32'hFF, 32'h0);
    rd(4'h1, 32'hF, 32'h3);
    rd(4'h5, 32'h3FF, 32'h3FF);
    rd(4'hF, 32'hFFFFFFFF, 32'h0);
    chk("abort", 32'h0, abort);
    @(posedge mclk_in);
    busy <= 1'b1;
    // peripheral frees up mid-transaction: retry must still stand
    fork
      go(32'h0, 1'b1, 1, 2'h1, 2'h2, 1'b1);
      begin
        repeat (3) @(posedge mclk_in);
        busy <= 1'b0;
      end
    join
    chk("irq", 32'h0, irq);
    rd(4'h2, 32'h2, 32'h2);
    go(32'h0, 1'b1, 1, 2'h1, 2'h3, 1'b1);
    wr(4'h1, 32'h8);
    go(32'h0, 1'b1, 1, 2'h1, 2'h3, 1'b1);
    chk("waits", 32'h1, core.wait_cnt > 0);
    chk("late", 32'h1, core.wait_cnt < 16);
    wr(4'h1, 32'h3);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_in);
      sel <= ts[i];
      busy <= tz[i];
      wr(4'h0, {24'h0, tc[i]});
      go(32'h0, 1'b1, 1, th[i], te[i], 1'b1);
    end
    @(posedge mclk_in);
    busy <= 1'b0;
    sel <= 1'b0;
    // transaction dependent controls behind one registered wait state
    wr(4'h0, 32'h3);
    go(32'h0, 1'b1, 1, 2'h1, 2'h1, 1'b1);
    chk("waitst", 32'h1, core.wait_cnt > 0);
    wr(4'h0, 32'h4);
    go(32'h14, 1'b1, 3, 2'h1, 2'h1, 1'b1);
    chk("ptr", 32'h8, ptr);
    rd(4'h4, 32'h3FF, 32'h8);
    go(32'h100, 1'b0, 2, 2'h1, 2'h1, 1'b1);
    chk("ptr", 32'h42, ptr);
    chk("abort", 32'h0, core.ab_seen);
    wr(4'h3, 32'h1);
    wr(4'h0, 32'h20);
    @(posedge mclk_in);
    fatal <= 1'b1;
    go(32'h0, 1'b1, 1, 2'h1, 2'h0, 1'b0);
    chk("status", 32'h1, core.signaled_abort_status_bit);
    chk("held", 32'h0, core.ab_drop);
    chk("irq", 32'h1, irq);
    @(posedge mclk_in);
    fatal <= 1'b0;
    rd(4'h2, 32'h1, 32'h1);
    chk("irq", 32'h0, irq);
    wr(4'h5, 32'h6);
    wr(4'h0, 32'h24);
    go(32'h14, 1'b1, 4, 2'h1, 2'h0, 1'b0);
    chk("abort", 32'h1, core.ab_seen);
    rd(4'h2, 32'h1, 32'h1);
    tally_and_finish();
  end
endmodule
